// >>> design/dpc_defines.vh
// Constants for the dual-port memory port controller
// Functional notes
// [R01] Memory access: select low, byte low, flag high
// [R02] Flag access: flag low, select or bytes high
// [R03] Selection held for whole write cycle
// [R04] Write happens during select, byte, strobe overlap
// [R05] Address changes only while write inactive
// [R06] Late select keeps device outputs off
// [R07] Strobe write lengthened when outputs enabled
// [R08] Read data valid after slowest access
// [R09] Old data held briefly after address change
// [R10] Select held long enough before write end
// [R11] Address valid early, set before write
// [R12] Write data setup before end, hold after
// [R13] Flag update pulse lasts minimum width
// [R14] Wait after flag write before verify read
// [R15] Separate competing flag writes between ports
// [R16] Flag read drives all data lines alike
// [R17] Select or bytes high through flag sequence
// [R18] Outputs released on strobe, redriven after write
// [R19] Do not drive data while outputs turn off
// [R20] Write recovery not negative
// [R21] Standby on deselect, instant power up
// [R22] Read waits port-to-port delay after opposite write
// [R23] Flag contention winner not guaranteed
// [R24] Both ports identical and independent
`ifndef DPC_DEFINES_VH
`define DPC_DEFINES_VH
`define DPC_CLK_NS 40
`define DPC_AW 13
`define DPC_DW 18
`define DPC_T_ACC_NS 25
`define DPC_T_WP_NS 20
`define DPC_T_HZ_NS 15
`define DPC_T_DW_NS 15
`define DPC_T_SOP_NS 10
`define DPC_T_SWRD_NS 5
`define DPC_T_WDD_NS 50
`define DPC_CYC(ns) (((ns) + `DPC_CLK_NS - 1) / `DPC_CLK_NS)
`define DPC_CW 3
`define DPC_SYNC_CYC 3
`endif

// >>> design/dpc_port_ctrl.v
// Host-side controller driving one port of the dual-port memory
`timescale 1ns/100ps
`include "dpc_defines.vh"
module dpc_port_ctrl (
  input wire clock_in,
  input wire rst_b_in,
  input wire req_in,
  input wire wr_in,
  input wire flag_in,
  input wire [1:0] byte_en_in,
  input wire [`DPC_AW-1:0] addr_in,
  input wire [`DPC_DW-1:0] wdata_in,
  input wire opp_write_in,
  output wire ready_out,
  output reg done_out,
  output reg [`DPC_DW-1:0] rdata_out,
  output reg [`DPC_AW-1:0] addr_out,
  output reg port_select_n_out,
  output reg upper_byte_sel_n_out,
  output reg lower_byte_sel_n_out,
  output reg flag_space_sel_n_out,
  output reg direction_strobe_out,
  output reg output_drive_en_n_out,
  output reg [`DPC_DW-1:0] data_out,
  output reg data_oe_out,
  input wire [`DPC_DW-1:0] data_in
);
  // ==================================================
  // Cycle counts
  // Reads also wait out the input synchroniser
  localparam integer I_ACC = `DPC_CYC(`DPC_T_ACC_NS) + `DPC_SYNC_CYC;
  localparam integer I_P2P = `DPC_CYC(`DPC_T_WDD_NS) + `DPC_SYNC_CYC;
  localparam integer I_HZ = `DPC_CYC(`DPC_T_HZ_NS);
  localparam integer I_WP = `DPC_CYC(`DPC_T_WP_NS);
  localparam integer I_GAP = `DPC_CYC(`DPC_T_SWRD_NS);
  localparam integer I_ONE = `DPC_CYC(1);
  localparam [`DPC_CW-1:0] C_ACC = I_ACC[`DPC_CW-1:0];
  localparam [`DPC_CW-1:0] C_P2P = I_P2P[`DPC_CW-1:0];
  localparam [`DPC_CW-1:0] C_HZ = I_HZ[`DPC_CW-1:0];
  localparam [`DPC_CW-1:0] C_WP = I_WP[`DPC_CW-1:0];
  localparam [`DPC_CW-1:0] C_GAP = I_GAP[`DPC_CW-1:0];
  localparam [`DPC_CW-1:0] C_ONE = I_ONE[`DPC_CW-1:0];

  // ==================================================
  // States
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_RD = 5'h02;
  localparam [4:0] S_WOFF = 5'h04;
  localparam [4:0] S_WR = 5'h08;
  localparam [4:0] S_END = 5'h10;
  reg [4:0] state_reg;
  reg [`DPC_CW-1:0] cnt_reg;
  reg [`DPC_DW-1:0] s1_reg, s2_reg, s3_reg;
  reg flag_reg;
  reg [`DPC_DW-1:0] wd_reg;
  reg wr_reg;
  reg sel_ps_next;
  reg sel_ub_next;
  reg sel_lb_next;
  reg sel_flag_next;
  reg done_next;
  wire take_req = ready_out & req_in;
  wire cnt_last = cnt_reg <= C_ONE;
  // Pin data counts once the last two stages agree
  wire data_ok = s2_reg == s3_reg;
  wire rd_take = (state_reg == S_RD) & cnt_last & data_ok;
  assign ready_out = state_reg == S_IDLE;

  // ==================================================
  // Data input synchroniser
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_reg <= {`DPC_DW{1'b0}};
      s2_reg <= {`DPC_DW{1'b0}};
      s3_reg <= {`DPC_DW{1'b0}};
    end else begin
      s1_reg <= data_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // ==================================================
  // Request capture
  // [R05] address moves only between accesses
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_out <= {`DPC_AW{1'b0}};
      flag_reg <= 1'b0;
      wr_reg <= 1'b0;
      wd_reg <= {`DPC_DW{1'b0}};
    end else if (take_req) begin
      addr_out <= addr_in;
      flag_reg <= flag_in;
      wr_reg <= wr_in;
      wd_reg <= wdata_in;
    end
  end

  // ==================================================
  // Selection decode
  // [R01] [R02] [R17] memory or flag space, never both
  always @* begin
    sel_ps_next = 1'b1;
    sel_ub_next = 1'b1;
    sel_lb_next = 1'b1;
    sel_flag_next = 1'b1;
    if (flag_in) begin
      sel_flag_next = 1'b0;
    end else if (|byte_en_in) begin
      sel_ps_next = 1'b0;
      sel_ub_next = ~byte_en_in[1];
      sel_lb_next = ~byte_en_in[0];
    end
  end

  // ==================================================
  // Completion pulse
  // One cycle: read data taken, or write fully closed
  always @* begin
    done_next = 1'b0;
    case (state_reg)
      S_RD: done_next = rd_take;
      S_END: done_next = cnt_last & wr_reg;
      default: done_next = 1'b0;
    endcase
  end

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= done_next;
    end
  end

  // ==================================================
  // Read data capture
  // [R16] flag read samples whole bus
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= {`DPC_DW{1'b0}};
    end else if (rd_take) begin
      rdata_out <= s3_reg;
    end
  end

  // ==================================================
  // Write data drive
  // [R19] bus stays released until the device has turned off
  // [R12] data stands before the pulse end and after it
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_out <= {`DPC_DW{1'b0}};
      data_oe_out <= 1'b0;
    end else if (state_reg == S_WOFF && cnt_last) begin
      data_out <= wd_reg;
      data_oe_out <= 1'b1;
    end else if (state_reg == S_END) begin
      data_oe_out <= 1'b0;
    end
  end

  // ==================================================
  // Access sequencer
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= S_IDLE;
      cnt_reg <= {`DPC_CW{1'b0}};
      port_select_n_out <= 1'b1;
      upper_byte_sel_n_out <= 1'b1;
      lower_byte_sel_n_out <= 1'b1;
      flag_space_sel_n_out <= 1'b1;
      direction_strobe_out <= 1'b1;
      output_drive_en_n_out <= 1'b1;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (take_req) begin
            // [R01] [R02] [R17] select memory or flags
            port_select_n_out <= sel_ps_next;
            upper_byte_sel_n_out <= sel_ub_next;
            lower_byte_sel_n_out <= sel_lb_next;
            flag_space_sel_n_out <= sel_flag_next;
            if (wr_in) begin
              // [R19] [R07] outputs off, wait turn-off time
              output_drive_en_n_out <= 1'b1;
              direction_strobe_out <= 1'b0;
              cnt_reg <= C_HZ;
              state_reg <= S_WOFF;
            end else begin
              // [R08] [R22] wait slowest access delay
              output_drive_en_n_out <= 1'b0;
              cnt_reg <= opp_write_in ? C_P2P : C_ACC;
              state_reg <= S_RD;
            end
          end
        end
        S_RD: begin
          if (rd_take) begin
            // Read closes: outputs off, port deselected
            output_drive_en_n_out <= 1'b1;
            port_select_n_out <= 1'b1;
            upper_byte_sel_n_out <= 1'b1;
            lower_byte_sel_n_out <= 1'b1;
            flag_space_sel_n_out <= 1'b1;
            cnt_reg <= C_ONE;
            state_reg <= S_END;
          end else if (!cnt_last) begin
            cnt_reg <= cnt_reg - C_ONE;
          end
        end
        S_WOFF: begin
          if (cnt_last) begin
            cnt_reg <= C_WP;
            state_reg <= S_WR;
          end else begin
            cnt_reg <= cnt_reg - C_ONE;
          end
        end
        S_WR: begin
          if (cnt_last) begin
            // [R03] [R10] [R11] [R13] pulse ends, selects held
            direction_strobe_out <= 1'b1;
            // [R14] [R15] flag write keeps a gap
            cnt_reg <= flag_reg ? C_GAP : C_ONE;
            state_reg <= S_END;
          end else begin
            cnt_reg <= cnt_reg - C_ONE;
          end
        end
        S_END: begin
          // [R20] selects drop after strobe
          port_select_n_out <= 1'b1;
          upper_byte_sel_n_out <= 1'b1;
          lower_byte_sel_n_out <= 1'b1;
          flag_space_sel_n_out <= 1'b1;
          if (cnt_last) begin
            state_reg <= S_IDLE;
          end else begin
            cnt_reg <= cnt_reg - C_ONE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

// >>> sim/dpc_chk_assertions.sv
// Pin protocol checker for the port controller
`timescale 1ns/100ps
`include "dpc_defines.vh"
module dpc_chk (
  input wire clock_in,
  input wire rst_b_in,
  input wire [`DPC_AW-1:0] addr_out,
  input wire port_select_n_out,
  input wire upper_byte_sel_n_out,
  input wire lower_byte_sel_n_out,
  input wire output_drive_en_n_out,
  input wire flag_space_sel_n_out,
  input wire direction_strobe_out,
  input wire data_oe_out
);
  // ==========
  // Properties
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_wlow;
    !direction_strobe_out ##1 !direction_strobe_out;
  endsequence
  property p_sel;
    !port_select_n_out |-> flag_space_sel_n_out;
  endproperty
  a_sel: assert property (p_sel) else $error("both spaces");
  property p_flg;
    !flag_space_sel_n_out |-> port_select_n_out;
  endproperty
  a_flg: assert property (p_flg) else $error("flag sel");
  property p_adr;
    $changed(addr_out) |-> $past(direction_strobe_out);
  endproperty
  a_adr: assert property (p_adr) else $error("addr in write");
  property p_drv;
    $rose(data_oe_out) |-> !$past(direction_strobe_out);
  endproperty
  a_drv: assert property (p_drv) else $error("early drive");
  property p_len;
    $fell(direction_strobe_out) |-> s_wlow;
  endproperty
  a_len: assert property (p_len) else $error("short pulse");
  property p_hld;
    $rose(direction_strobe_out) |-> data_oe_out;
  endproperty
  a_hld: assert property (p_hld) else $error("no hold");
  property p_stb;
    !direction_strobe_out && !$past(direction_strobe_out) |->
      $stable(port_select_n_out) && $stable(flag_space_sel_n_out);
  endproperty
  a_stb: assert property (p_stb) else $error("sel moved");
  property p_sop;
    $fell(flag_space_sel_n_out) |=> !flag_space_sel_n_out;
  endproperty
  a_sop: assert property (p_sop) else $error("flag pulse");
  property p_byt;
    !flag_space_sel_n_out |-> upper_byte_sel_n_out && lower_byte_sel_n_out;
  endproperty
  a_byt: assert property (p_byt) else $error("lane in flag");
  property p_lan;
    !upper_byte_sel_n_out || !lower_byte_sel_n_out |-> !port_select_n_out;
  endproperty
  a_lan: assert property (p_lan) else $error("lane no sel");
  property p_oen;
    !direction_strobe_out |-> output_drive_en_n_out;
  endproperty
  a_oen: assert property (p_oen) else $error("oe in write");
endmodule
bind dpc_port_ctrl dpc_chk u_chk (.clock_in, .rst_b_in, .addr_out,
  .port_select_n_out, .upper_byte_sel_n_out, .lower_byte_sel_n_out,
  .output_drive_en_n_out, .flag_space_sel_n_out, .direction_strobe_out,
  .data_oe_out);

// >>> sim/dpc_dev_model.sv
// Behavioural model of one memory port
`timescale 1ns/100ps
module dpc_dev_model #(parameter T_ACC = 25) (
  input wire [12:0] addr_in,
  input wire ps_n_in,
  input wire upper_byte_sel_n_in,
  input wire lower_byte_sel_n_in,
  input wire flag_space_sel_n_in,
  input wire strobe_in,
  input wire oe_n_in,
  input wire [17:0] bus_in,
  output wire [17:0] dq_out
);
  // ==========
  // Array and flag
  reg [17:0] mem [0:8191];
  reg flag_reg = 1'b1;
  wire no_lane = upper_byte_sel_n_in && lower_byte_sel_n_in;
  wire mem_sel = !ps_n_in && !no_lane && flag_space_sel_n_in;
  wire sem_sel = !flag_space_sel_n_in && (ps_n_in || no_lane);
  wire [17:0] val = sem_sel ? {18{flag_reg}} : mem[addr_in];
  // lanes written at end of overlap
  always @(posedge strobe_in) begin
    if (mem_sel && !upper_byte_sel_n_in) mem[addr_in][17:9] <= bus_in[17:9];
    if (mem_sel && !lower_byte_sel_n_in) mem[addr_in][8:0] <= bus_in[8:0];
    if (sem_sel) flag_reg <= bus_in[0];
  end
  // delayed drive, old data held, complement of the stored word unless selected for a read
  assign #(T_ACC) dq_out = (mem_sel || sem_sel) && !oe_n_in && strobe_in ?
    val : ~val;
endmodule

// >>> sim/tb_dual_port_ram_async_access.sv
// Self-checking bench for the port controller
`timescale 1ns/100ps
`include "dpc_defines.vh"
module tb_dual_port_ram_async_access;
  localparam integer L_RD = `DPC_CYC(`DPC_T_ACC_NS) + `DPC_SYNC_CYC;
  localparam integer L_P2P = `DPC_CYC(`DPC_T_WDD_NS) + `DPC_SYNC_CYC;
  localparam integer L_WR = `DPC_CYC(`DPC_T_HZ_NS) +
    `DPC_CYC(`DPC_T_WP_NS) + 1;
  integer lat = 0;
  reg clock_in = 0, rst_b_in = 0, req_in = 0, wr_in = 0, flag_in = 0;
  reg opp_write_in = 0;
  reg [1:0] byte_en_in = 0;
  reg [12:0] addr_in = 13'h1FFF;
  reg [17:0] wdata_in = 0;
  wire ready_out, done_out, port_select_n_out, upper_byte_sel_n_out;
  wire lower_byte_sel_n_out, flag_space_sel_n_out, direction_strobe_out;
  wire output_drive_en_n_out, data_oe_out;
  wire [17:0] rdata_out, data_out, dq, bus;
  wire [12:0] addr_out;
  integer n_fail = 0, checked = 0;
  always #20 clock_in = ~clock_in;
  assign bus = data_oe_out ? data_out : dq;
  dpc_port_ctrl DUT (.clock_in, .rst_b_in, .req_in, .wr_in, .flag_in,
    .byte_en_in, .addr_in, .wdata_in, .opp_write_in, .ready_out, .done_out,
    .rdata_out, .addr_out, .port_select_n_out, .upper_byte_sel_n_out,
    .lower_byte_sel_n_out, .flag_space_sel_n_out, .direction_strobe_out,
    .output_drive_en_n_out, .data_out, .data_oe_out, .data_in(bus));
  dpc_dev_model u_dev (.addr_in(addr_out), .ps_n_in(port_select_n_out),
    .upper_byte_sel_n_in(upper_byte_sel_n_out),
    .lower_byte_sel_n_in(lower_byte_sel_n_out),
    .flag_space_sel_n_in(flag_space_sel_n_out),
    .strobe_in(direction_strobe_out), .oe_n_in(output_drive_en_n_out),
    .bus_in(bus), .dq_out(dq));
  // ==========
  // Tasks
  task chk(input [17:0] got, input [17:0] exp); begin
    checked = checked + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  end endtask
  task op(input w, input f, input [1:0] b, input [17:0] d); integer i; begin
    @(negedge clock_in);
    chk({17'h0, ready_out}, 18'h1);
    req_in = 1; wr_in = w; flag_in = f; byte_en_in = b; wdata_in = d;
    @(negedge clock_in);
    req_in = 0;
    for (i = 0; i < 9 && done_out !== 1'b1; i = i + 1) @(negedge clock_in);
    lat = i;
    chk({17'h0, done_out}, 18'h1);
  end endtask
  task t_mem; begin
    op(1, 0, 2'h3, 18'h3ABCD);
    chk(lat[17:0], L_WR[17:0]);
    op(0, 0, 2'h3, 0);
    chk(lat[17:0], L_RD[17:0]);
    chk(rdata_out, 18'h3ABCD);
    op(1, 0, 2'h2, 0); op(0, 0, 2'h3, 0);
    chk(rdata_out, 18'h001CD);
    addr_in = 13'h0A55;
    op(1, 0, 2'h3, 18'h15555); op(0, 0, 2'h3, 0);
    chk(rdata_out, 18'h15555);
    addr_in = 13'h1FFF;
    op(0, 0, 2'h3, 0);
    chk(rdata_out, 18'h001CD);
    $display("memory test ended");
  end endtask
  task t_flag; begin
    op(1, 1, 2'h0, 0); op(0, 1, 2'h0, 0);
    chk(rdata_out, 18'h00000);
    op(1, 1, 2'h0, 18'h1); op(0, 1, 2'h0, 0);
    chk(rdata_out, 18'h3FFFF);
    $display("flag test ended");
  end endtask
  task t_opp; begin
    opp_write_in = 1; op(0, 0, 2'h3, 0); opp_write_in = 0;
    chk(lat[17:0], L_P2P[17:0]);
    chk(rdata_out, 18'h001CD);
    $display("opposite write test ended");
  end endtask
  task close_out; begin
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end endtask
  initial begin
    repeat (3) @(negedge clock_in);
    rst_b_in = 1;
    t_mem; t_flag; t_opp;
    close_out;
  end
  initial begin
    #100000;
    n_fail = n_fail + 1;
    close_out;
  end
endmodule
